//--- hw/xem_pkg.sv
// constants, types and decode helpers for the external-move access block
// Function
// R1: on-chip RAM mapped into external data space
// R2: 8-bit form: page high, index low
// R3: 16-bit form uses full data pointer
// R4: data pointer high/low byte registers
// R5: non-flash moves route to external data space
// R6: FIFO window 0x0400-0x07FF when enabled
// R7: software keeps usb clock >= twice system
// R8: window hides overlapping RAM and off-chip
// R9: FIFO accesses take extra cycles
// R10: software avoids moves on USB packet data
// R11: software configures interface in stated order
// R12: interface drives address, data, strobe pins
// R13: software skips strobe pins in crossbar
// R14: pins claimed only during off-chip move
// R15: software parks pins at inactive level
// R16: input pins undriven during off-chip access
// R17: pin output mode left unchanged
// R18: mode field selects on, split, off-chip
// R19: split without bank leaves A15-8 undriven; the code still drives them for the 16-bit form
// R20: mux bit selects shared or separate pins
// R21: latch strobe high/low width 1-4 cycles
// R22: internal-only wraps address modulo RAM size
package xem_pkg;
	localparam int          RAM_AW    = 12;
	localparam int          FIFO_AW   = 10;
	localparam logic [15:0] RAM_TOP   = 16'h1000;
	localparam logic [15:0] FIFO_LO   = 16'h0400;
	localparam logic [15:0] FIFO_HI   = 16'h07FF;
	localparam logic [2:0]  FIFO_WAIT = 3'h3;
	localparam logic [2:0]  STB_WAIT  = 3'h1;
	localparam logic [7:0]  OFF_PAGE  = 8'h00;
	localparam logic [7:0]  OFF_CFG   = 8'h04;
	localparam logic [7:0]  OFF_DPH   = 8'h08;
	localparam logic [7:0]  OFF_DPL   = 8'h0C;
	localparam logic [7:0]  OFF_IDX0  = 8'h10;
	localparam logic [7:0]  OFF_IDX1  = 8'h14;
	localparam logic [7:0]  OFF_CMD   = 8'h18;
	localparam logic [7:0]  OFF_STAT  = 8'h1C;
	localparam logic [7:0]  CFG_RST   = 8'h03;
	localparam logic [7:0]  CFG_MASK  = 8'h5F;
	localparam int          CFG_FAE   = 6;
	localparam int          CFG_SEP   = 4;
	localparam int          CFG_MODE  = 2;
	localparam int          CMD_WR    = 8;
	localparam int          CMD_F16   = 9;
	localparam int          CMD_IDX   = 10;
	localparam int          CMD_FLASH = 11;
	localparam int          STAT_BUSY = 8;
	localparam int          STAT_TGT  = 9;
	localparam logic [1:0]  MODE_INT  = 2'h0;
	localparam logic [1:0]  MODE_NOBK = 2'h1;
	localparam logic [1:0]  MODE_EXT  = 2'h3;
	localparam logic [1:0]  RESP_OK   = 2'h0;
	localparam logic [1:0]  RESP_ERR  = 2'h2;

	typedef enum logic [2:0] {TGT_NONE, TGT_RAM, TGT_FIFO, TGT_EXT, TGT_FLASH} xem_tgt_t;

	function automatic xem_tgt_t xem_route(input logic [15:0] a, input logic [1:0] mode,
		input logic fae, input logic flash_wr);
		if (flash_wr)
			return TGT_FLASH;
		if (fae && a >= FIFO_LO && a <= FIFO_HI)
			return TGT_FIFO;
		if (mode == MODE_INT)
			return TGT_RAM;
		if (mode == MODE_EXT)
			return TGT_EXT;
		return (a < RAM_TOP) ? TGT_RAM : TGT_EXT;
	endfunction : xem_route

	function automatic logic [3:0] xem_reg_idx(input logic [7:0] a);
		return {(a <= OFF_STAT) && (a[1:0] == 2'h0), a[4:2]};
	endfunction : xem_reg_idx
endpackage : xem_pkg

//--- hw/xem_mem_if.sv
// request and read path between the access engine and the on-chip RAM
`timescale 1ns/10ps
`default_nettype none
interface xem_mem_if;
	logic        en;
	logic        we;
	logic [11:0] addr;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	modport ctrl (output en, output we, output addr, output wdata, input rdata);
	modport mem  (input en, input we, input addr, input wdata, output rdata);
endinterface : xem_mem_if
`default_nettype wire

//--- hw/xem_external_data_space_mem.sv
// on-chip data RAM with registered read data
`timescale 1ns/10ps
`default_nettype none
module xem_external_data_space_mem (
	input wire logic clock,
	xem_mem_if.mem   port
);
	logic [7:0] ram [0:(1 << xem_pkg::RAM_AW) - 1];
	logic [7:0] rdata_ff;

	always_ff @(posedge clock) begin
		if (port.en && port.we)
			ram[port.addr] <= port.wdata;
	end

	always_ff @(posedge clock) begin
		if (port.en && !port.we)
			rdata_ff <= ram[port.addr];
	end

	assign port.rdata = rdata_ff;
endmodule : xem_external_data_space_mem
`default_nettype wire

//--- hw/xem_external_data_space_access.sv
// external-move address generation, routing and off-chip pin sequencing
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module xem_external_data_space_access (
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             fifo_req,
	output logic             fifo_we,
	output logic [9:0]       fifo_addr,
	output logic [7:0]       fifo_wdata,
	input  wire logic [7:0]  fifo_rdata,
	output logic [7:0]       ext_ahi_out,
	output logic             ext_ahi_oe,
	output logic [7:0]       ext_alo_out,
	output logic             ext_alo_oe,
	output logic [7:0]       ext_data_out,
	output logic             ext_data_oe,
	input  wire logic [7:0]  ext_data_in,
	output logic             ext_wr_n_out,
	output logic             ext_wr_n_oe,
	output logic             ext_rd_n_out,
	output logic             ext_rd_n_oe,
	output logic             ext_ale_out,
	output logic             ext_ale_oe
);
	typedef enum logic [3:0] {
		ST_IDLE, ST_LAUNCH, ST_RAM_REQ, ST_RAM_RD, ST_FIFO,
		ST_ALE_HI, ST_ALE_LO, ST_STROBE, ST_RELEASE
	} xem_state_t;

	xem_mem_if mem ();

	xem_external_data_space_mem u_mem (
		.clock (clock),
		.port  (mem.mem)
	);

	////////////////////////////////////////////////////////////////////////////////
	// register bus slave
	logic        awrdy_ff, wrdy_ff, bvalid_ff, arrdy_ff, rvalid_ff;
	logic        aw_hold_ff, w_hold_ff;
	logic [7:0]  awaddr_ff;
	logic [31:0] wdata_ff, rdata_ff;
	logic [3:0]  wstrb_ff;
	logic [1:0]  bresp_ff, rresp_ff;
	logic        nxt_aw_hold, nxt_w_hold, nxt_bvalid, nxt_rvalid;
	logic        do_write, do_read;
	logic [3:0]  wsel, rsel;

	assign do_write = aw_hold_ff && w_hold_ff && !bvalid_ff;
	assign do_read  = s_axi_arvalid && arrdy_ff;
	assign wsel     = xem_pkg::xem_reg_idx(awaddr_ff);
	assign rsel     = xem_pkg::xem_reg_idx(s_axi_araddr);

	always_comb begin
		nxt_aw_hold = do_write ? 1'b0 : (aw_hold_ff || (s_axi_awvalid && awrdy_ff));
		nxt_w_hold  = do_write ? 1'b0 : (w_hold_ff || (s_axi_wvalid && wrdy_ff));
		nxt_bvalid  = bvalid_ff ? !s_axi_bready : do_write;
		nxt_rvalid  = rvalid_ff ? !s_axi_rready : do_read;
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			awrdy_ff   <= 1'b0;
			wrdy_ff    <= 1'b0;
			aw_hold_ff <= 1'b0;
			w_hold_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= xem_pkg::RESP_OK;
			awaddr_ff  <= 8'h00;
			wdata_ff   <= 32'h0000_0000;
			wstrb_ff   <= 4'h0;
		end else begin
			aw_hold_ff <= nxt_aw_hold;
			w_hold_ff  <= nxt_w_hold;
			bvalid_ff  <= nxt_bvalid;
			awrdy_ff   <= !nxt_aw_hold && !nxt_bvalid;
			wrdy_ff    <= !nxt_w_hold && !nxt_bvalid;
			if (s_axi_awvalid && awrdy_ff)
				awaddr_ff <= s_axi_awaddr;
			if (s_axi_wvalid && wrdy_ff) begin
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			if (do_write)
				bresp_ff <= wsel[3] ? xem_pkg::RESP_OK : xem_pkg::RESP_ERR;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// software registers
	logic [7:0]        page_ff, cfg_ff, dph_ff, dpl_ff, idx0_ff, idx1_ff, rd_byte_ff;
	xem_state_t        state_ff, nxt_state;
	xem_pkg::xem_tgt_t tgt_ff, nxt_tgt;
	logic              cmd_go, cmd_wr, cmd_flash;
	logic [15:0]       nxt_ea;
	logic [7:0]        lane0;

	assign lane0     = wdata_ff[7:0];
	assign cmd_go    = do_write && wsel == {1'b1, xem_pkg::OFF_CMD[4:2]} && wstrb_ff[1]
		&& state_ff == ST_IDLE;
	assign cmd_wr    = wdata_ff[xem_pkg::CMD_WR];
	assign cmd_flash = wdata_ff[xem_pkg::CMD_FLASH];
	// 16-bit form from pointer, 8-bit form from page and index
	assign nxt_ea    = wdata_ff[xem_pkg::CMD_F16] ? {dph_ff, dpl_ff} : // R3
		{page_ff, wdata_ff[xem_pkg::CMD_IDX] ? idx1_ff : idx0_ff}; // R2
	// R5 R6 R8 R18
	assign nxt_tgt   = xem_pkg::xem_route(nxt_ea, cfg_ff[xem_pkg::CFG_MODE +: 2],
		cfg_ff[xem_pkg::CFG_FAE], cmd_wr && cmd_flash);

	always_ff @(posedge clock) begin
		if (srst) begin
			page_ff <= 8'h00;
			cfg_ff  <= xem_pkg::CFG_RST;
			dph_ff  <= 8'h00;
			dpl_ff  <= 8'h00;
			idx0_ff <= 8'h00;
			idx1_ff <= 8'h00;
		end else if (do_write && wstrb_ff[0]) begin
			case (wsel)
				{1'b1, xem_pkg::OFF_PAGE[4:2]}: page_ff <= lane0;
				{1'b1, xem_pkg::OFF_CFG[4:2]}:  cfg_ff  <= lane0 & xem_pkg::CFG_MASK;
				{1'b1, xem_pkg::OFF_DPH[4:2]}:  dph_ff  <= lane0; // R4
				{1'b1, xem_pkg::OFF_DPL[4:2]}:  dpl_ff  <= lane0; // R4
				{1'b1, xem_pkg::OFF_IDX0[4:2]}: idx0_ff <= lane0;
				{1'b1, xem_pkg::OFF_IDX1[4:2]}: idx1_ff <= lane0;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			arrdy_ff  <= 1'b0;
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0000_0000;
			rresp_ff  <= xem_pkg::RESP_OK;
		end else begin
			rvalid_ff <= nxt_rvalid;
			arrdy_ff  <= !nxt_rvalid;
			if (do_read) begin
				rresp_ff <= rsel[3] ? xem_pkg::RESP_OK : xem_pkg::RESP_ERR;
				case (rsel)
					{1'b1, xem_pkg::OFF_PAGE[4:2]}: rdata_ff <= {24'h0, page_ff};
					{1'b1, xem_pkg::OFF_CFG[4:2]}:  rdata_ff <= {24'h0, cfg_ff};
					{1'b1, xem_pkg::OFF_DPH[4:2]}:  rdata_ff <= {24'h0, dph_ff};
					{1'b1, xem_pkg::OFF_DPL[4:2]}:  rdata_ff <= {24'h0, dpl_ff};
					{1'b1, xem_pkg::OFF_IDX0[4:2]}: rdata_ff <= {24'h0, idx0_ff};
					{1'b1, xem_pkg::OFF_IDX1[4:2]}: rdata_ff <= {24'h0, idx1_ff};
					{1'b1, xem_pkg::OFF_STAT[4:2]}: rdata_ff <= {20'h0, tgt_ff,
						state_ff != ST_IDLE, rd_byte_ff};
					default: rdata_ff <= 32'h0000_0000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// access engine
	logic [15:0] ea_ff;
	logic [7:0]  acc_wdata_ff;
	logic [2:0]  cnt_ff;
	logic        wr_ff, f16_ff, sep_ff;
	logic [1:0]  mode_ff, alew_ff;

	always_ff @(posedge clock) begin
		if (srst) begin
			ea_ff        <= 16'h0000;
			tgt_ff       <= xem_pkg::TGT_NONE;
			wr_ff        <= 1'b0;
			f16_ff       <= 1'b0;
			sep_ff       <= 1'b0;
			mode_ff      <= xem_pkg::MODE_INT;
			alew_ff      <= 2'h0;
			acc_wdata_ff <= 8'h00;
		end else if (cmd_go) begin
			ea_ff        <= nxt_ea;
			tgt_ff       <= nxt_tgt;
			wr_ff        <= cmd_wr;
			f16_ff       <= wdata_ff[xem_pkg::CMD_F16];
			sep_ff       <= cfg_ff[xem_pkg::CFG_SEP]; // R20
			mode_ff      <= cfg_ff[xem_pkg::CFG_MODE +: 2];
			alew_ff      <= cfg_ff[1:0];
			acc_wdata_ff <= lane0;
		end
	end

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE:
				if (cmd_go)
					nxt_state = ST_LAUNCH;
			ST_LAUNCH:
				case (tgt_ff)
					xem_pkg::TGT_RAM:  nxt_state = ST_RAM_REQ;
					xem_pkg::TGT_FIFO: nxt_state = ST_FIFO;
					xem_pkg::TGT_EXT:  nxt_state = sep_ff ? ST_STROBE : ST_ALE_HI; // R20
					default:           nxt_state = ST_IDLE;
				endcase
			ST_RAM_REQ: nxt_state = ST_RAM_RD;
			ST_RAM_RD:  nxt_state = ST_IDLE;
			ST_FIFO:
				if (cnt_ff == 3'h0)
					nxt_state = ST_IDLE;
			ST_ALE_HI:
				if (cnt_ff == 3'h0)
					nxt_state = ST_ALE_LO;
			ST_ALE_LO:
				if (cnt_ff == 3'h0)
					nxt_state = ST_STROBE;
			ST_STROBE:
				if (cnt_ff == 3'h0)
					nxt_state = ST_RELEASE;
			ST_RELEASE: nxt_state = ST_IDLE;
			default:    nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state_ff <= ST_IDLE;
			cnt_ff   <= 3'h0;
		end else begin
			state_ff <= nxt_state;
			if (nxt_state != state_ff) begin
				case (nxt_state)
					ST_FIFO:   cnt_ff <= xem_pkg::FIFO_WAIT; // R7 R9
					ST_ALE_HI: cnt_ff <= {1'b0, alew_ff}; // R21
					ST_ALE_LO: cnt_ff <= {1'b0, alew_ff}; // R21
					ST_STROBE: cnt_ff <= xem_pkg::STB_WAIT;
					default:   cnt_ff <= 3'h0;
				endcase
			end else if (cnt_ff != 3'h0) begin
				cnt_ff <= cnt_ff - 3'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// on-chip RAM and FIFO window requests
	logic        mem_en_ff, fifo_req_ff;

	always_ff @(posedge clock) begin
		if (srst) begin
			mem_en_ff   <= 1'b0;
			fifo_req_ff <= 1'b0;
		end else begin
			mem_en_ff   <= nxt_state == ST_RAM_REQ; // R1
			fifo_req_ff <= nxt_state == ST_FIFO; // R6
		end
	end

	assign mem.en    = mem_en_ff;
	assign mem.we    = wr_ff;
	// low bits only, so addresses past the RAM alias onto it
	assign mem.addr  = ea_ff[xem_pkg::RAM_AW - 1:0]; // R1 R22
	assign mem.wdata = acc_wdata_ff;

	always_ff @(posedge clock) begin
		if (srst)
			rd_byte_ff <= 8'h00;
		else if (state_ff == ST_RAM_RD && !wr_ff)
			rd_byte_ff <= mem.rdata;
		else if (state_ff == ST_FIFO && cnt_ff == 3'h0 && !wr_ff)
			rd_byte_ff <= fifo_rdata;
		else if (state_ff == ST_STROBE && cnt_ff == 3'h0 && !wr_ff)
			rd_byte_ff <= ext_data_in;
	end

	////////////////////////////////////////////////////////////////////////////////
	// off-chip pins
	logic       ext_on, addr_ph;
	logic [7:0] ahi_ff, alo_ff, dout_ff;
	logic       ahi_oe_ff, alo_oe_ff, dout_oe_ff, wr_n_ff, rd_n_ff, ctl_oe_ff, ale_ff, ale_oe_ff;

	assign ext_on  = nxt_state inside {ST_ALE_HI, ST_ALE_LO, ST_STROBE, ST_RELEASE};
	assign addr_ph = nxt_state inside {ST_ALE_HI, ST_ALE_LO};

	always_ff @(posedge clock) begin
		if (srst) begin
			ahi_ff     <= 8'hFF;
			alo_ff     <= 8'hFF;
			dout_ff    <= 8'hFF;
			ahi_oe_ff  <= 1'b0;
			alo_oe_ff  <= 1'b0;
			dout_oe_ff <= 1'b0;
			wr_n_ff    <= 1'b1;
			rd_n_ff    <= 1'b1;
			ctl_oe_ff  <= 1'b0;
			ale_ff     <= 1'b0;
			ale_oe_ff  <= 1'b0;
		end else begin
			ahi_ff     <= ea_ff[15:8];
			alo_ff     <= ea_ff[7:0];
			dout_ff    <= (!sep_ff && addr_ph) ? ea_ff[7:0] : acc_wdata_ff;
			// pins claimed only while the off-chip move runs
			ahi_oe_ff  <= ext_on && (f16_ff || mode_ff != xem_pkg::MODE_NOBK); // R12 R14 R19
			alo_oe_ff  <= ext_on && sep_ff; // R12 R20
			// data drivers stay off in the read data phase
			dout_oe_ff <= ext_on && ((!sep_ff && addr_ph) || (!addr_ph && wr_ff)); // R16
			wr_n_ff    <= !(nxt_state == ST_STROBE && wr_ff);
			rd_n_ff    <= !(nxt_state == ST_STROBE && !wr_ff);
			ctl_oe_ff  <= ext_on; // R14
			ale_ff     <= nxt_state == ST_ALE_HI; // R21
			ale_oe_ff  <= ext_on && !sep_ff;
		end
	end

	// output drive type stays with the port mode registers outside
	assign ext_ahi_out   = ahi_ff; // R17
	assign ext_ahi_oe    = ahi_oe_ff;
	assign ext_alo_out   = alo_ff;
	assign ext_alo_oe    = alo_oe_ff;
	assign ext_data_out  = dout_ff;
	assign ext_data_oe   = dout_oe_ff;
	assign ext_wr_n_out  = wr_n_ff;
	assign ext_wr_n_oe   = ctl_oe_ff;
	assign ext_rd_n_out  = rd_n_ff;
	assign ext_rd_n_oe   = ctl_oe_ff;
	assign ext_ale_out   = ale_ff;
	assign ext_ale_oe    = ale_oe_ff;
	assign fifo_req      = fifo_req_ff;
	assign fifo_we       = wr_ff;
	assign fifo_addr     = ea_ff[xem_pkg::FIFO_AW - 1:0];
	assign fifo_wdata    = acc_wdata_ff;
	assign s_axi_awready = awrdy_ff;
	assign s_axi_wready  = wrdy_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = arrdy_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	ea_page_a: assert property (cmd_go && !wdata_ff[xem_pkg::CMD_F16] |=> // R2
		ea_ff == {$past(page_ff), $past(wdata_ff[xem_pkg::CMD_IDX]) ? $past(idx1_ff)
		: $past(idx0_ff)}) else $error("8-bit address not page and index");
	ea_data_pointer_a: assert property (cmd_go && wdata_ff[xem_pkg::CMD_F16] |=> // R3
		ea_ff == {$past(dph_ff), $past(dpl_ff)}) else $error("16-bit address not pointer");
	fifo_win_a: assert property (state_ff == ST_LAUNCH && tgt_ff == xem_pkg::TGT_FIFO // R6
		|=> fifo_req && fifo_addr == ea_ff[9:0] && ea_ff >= xem_pkg::FIFO_LO
		&& ea_ff <= xem_pkg::FIFO_HI) else $error("window access misrouted");
	fifo_slow_a: assert property ($rose(fifo_req) |-> fifo_req [*4]) // R9
		else $error("window access too short");
	flash_skip_a: assert property (state_ff == ST_LAUNCH && tgt_ff == xem_pkg::TGT_FLASH // R5
		|=> state_ff == ST_IDLE && !mem_en_ff && !fifo_req && !ctl_oe_ff)
		else $error("flash write touched data space");
	pins_idle_a: assert property (state_ff == ST_IDLE |-> !ctl_oe_ff && !dout_oe_ff // R14
		&& !ahi_oe_ff) else $error("pins driven outside access");
	rd_no_drv_a: assert property (!rd_n_ff |-> !dout_oe_ff) // R16
		else $error("data driven during read");
	nobank_hi_a: assert property (ext_on && !f16_ff && mode_ff == xem_pkg::MODE_NOBK // R19
		|=> ctl_oe_ff && !ahi_oe_ff) else $error("high address driven without bank");
	ale_width_a: assert property ($rose(ale_ff) && alew_ff == 2'h2 |-> // R21
		ale_ff [*3] ##1 !ale_ff [*3] ##1 !rd_n_ff || !wr_n_ff)
		else $error("latch strobe width wrong");
	wrap_a: assert property (state_ff == ST_LAUNCH && mode_ff == xem_pkg::MODE_INT // R22
		&& tgt_ff != xem_pkg::TGT_FIFO && tgt_ff != xem_pkg::TGT_FLASH
		|=> mem_en_ff && mem.addr == ea_ff[11:0])
		else $error("internal access not wrapped");

	ram_c: cover property (state_ff == ST_RAM_RD && !wr_ff);
	fifo_c: cover property ($fell(fifo_req) && wr_ff);
	mux_c: cover property ($fell(ale_ff) && !wr_ff);
	sep_c: cover property (!wr_n_ff && sep_ff);
endmodule : xem_external_data_space_access
`default_nettype wire

//--- tb/xem_ext_sram.sv
// off-chip sram model standing on the external memory port pins
`timescale 1ns/10ps
`default_nettype none
module xem_ext_sram (
	input  wire logic       clock,
	input  wire logic [7:0] hi_latch,
	input  wire logic [7:0] ahi_out,
	input  wire logic       ahi_oe,
	input  wire logic [7:0] alo_out,
	input  wire logic       alo_oe,
	input  wire logic [7:0] data_out,
	input  wire logic       data_oe,
	input  wire logic       wr_n_out,
	input  wire logic       wr_n_oe,
	input  wire logic       rd_n_out,
	input  wire logic       rd_n_oe,
	input  wire logic       ale_out,
	input  wire logic       ale_oe,
	output logic [7:0]      data_in
);
	logic [7:0]  mem [0:65535];
	logic [7:0]  lat;
	logic [15:0] addr;
	logic        wr_n;
	logic        rd_n;
	logic        ale;

	////////////////////////////////////////////////////////////////////////////////
	// released pins fall back to the parked port latch levels
	always_comb begin
		wr_n = wr_n_oe ? wr_n_out : 1'b1;
		rd_n = rd_n_oe ? rd_n_out : 1'b1;
		ale = ale_oe ? ale_out : 1'b1;
		addr = {ahi_oe ? ahi_out : hi_latch, alo_oe ? alo_out : lat};
		if (data_oe)
			data_in = data_out;
		else if (!rd_n)
			data_in = mem[addr];
		else
			data_in = 8'hFF;
	end

	////////////////////////////////////////////////////////////////////////////////
	// address latch follows the shared lines while the latch strobe is high
	always @(posedge clock) begin
		if (ale)
			lat <= data_in;
		if (!wr_n)
			mem[addr] <= data_in;
	end
endmodule : xem_ext_sram
`default_nettype wire

//--- tb/external_data_space_external_memory_access_bench.sv
// self-checking bench for the external-move access block
`timescale 1ns/10ps
`default_nettype none
module external_data_space_external_memory_access_bench;
	typedef struct packed {
		logic [7:0] cfg;
		logic [7:0] hi;
		logic [7:0] lo;
		logic [3:0] ctl;
		logic [7:0] wd;
		logic [2:0] tgt;
		logic [7:0] rd;
	} xem_row_t;
	logic        clock, srst, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic        f_req, f_we, ahi_e, alo_e, d_e, wr_o, wr_e, rd_o, rd_e, ale_o, ale_e;
	logic [9:0]  f_addr;
	logic [7:0]  f_wd, f_rd, ahi_o, alo_o, d_o, d_i;
	logic [7:0]  fmem [0:1023];
	logic        claim, ahi_seen, ale_seen;
	int          ale_run, ale_len, req_run, req_len, cyc, fail_count, cmp_count;
	xem_row_t    rows [18] = '{
		{8'h1C, 8'h12, 8'h34, 4'h3, 8'hA5, 3'h3, 8'h00}, {8'h1C, 8'h12, 8'h34, 4'h2, 8'h00, 3'h3, 8'hA5},
		{8'h0E, 8'h12, 8'h35, 4'h3, 8'h77, 3'h3, 8'h00}, {8'h1C, 8'h12, 8'h35, 4'h2, 8'h00, 3'h3, 8'h77},
		{8'h0F, 8'h12, 8'h34, 4'h2, 8'h00, 3'h3, 8'hA5}, {8'h10, 8'h00, 8'h10, 4'h3, 8'h5A, 3'h1, 8'h00},
		{8'h10, 8'h10, 8'h10, 4'h2, 8'h00, 3'h1, 8'h5A}, {8'h10, 8'h00, 8'h10, 4'h0, 8'h00, 3'h1, 8'h5A},
		{8'h10, 8'h00, 8'h10, 4'h4, 8'h00, 3'h1, 8'h5A}, {8'h50, 8'h04, 8'h00, 4'h3, 8'hC3, 3'h2, 8'h00},
		{8'h5C, 8'h04, 8'h00, 4'h2, 8'h00, 3'h2, 8'hC3}, {8'h14, 8'h20, 8'h00, 4'h3, 8'h3C, 3'h3, 8'h00},
		{8'h14, 8'h0F, 8'hFF, 4'h3, 8'hE1, 3'h1, 8'h00}, {8'h14, 8'h0F, 8'hFF, 4'h2, 8'h00, 3'h1, 8'hE1},
		{8'h18, 8'h20, 8'h00, 4'h0, 8'h00, 3'h3, 8'h3C}, {8'h14, 8'h20, 8'h00, 4'h0, 8'h00, 3'h3, 8'h3C},
		{8'h1C, 8'h12, 8'h34, 4'hB, 8'h99, 3'h4, 8'h00}, {8'h1C, 8'h12, 8'h34, 4'hA, 8'h00, 3'h3, 8'hA5}};
	logic [7:0]  ro [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C};
	logic [7:0]  rv [7] = '{8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	xem_external_data_space_access dut (.clock(clock), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fifo_req(f_req),
		.fifo_we(f_we), .fifo_addr(f_addr), .fifo_wdata(f_wd), .fifo_rdata(f_rd),
		.ext_ahi_out(ahi_o), .ext_ahi_oe(ahi_e), .ext_alo_out(alo_o), .ext_alo_oe(alo_e),
		.ext_data_out(d_o), .ext_data_oe(d_e), .ext_data_in(d_i), .ext_wr_n_out(wr_o),
		.ext_wr_n_oe(wr_e), .ext_rd_n_out(rd_o), .ext_rd_n_oe(rd_e), .ext_ale_out(ale_o),
		.ext_ale_oe(ale_e));

	xem_ext_sram sram (.clock(clock), .hi_latch(8'h20), .ahi_out(ahi_o), .ahi_oe(ahi_e),
		.alo_out(alo_o), .alo_oe(alo_e), .data_out(d_o), .data_oe(d_e), .wr_n_out(wr_o),
		.wr_n_oe(wr_e), .rd_n_out(rd_o), .rd_n_oe(rd_e), .ale_out(ale_o), .ale_oe(ale_e),
		.data_in(d_i));

	////////////////////////////////////////////////////////////////////////////////
	// usb-side window memory, data ready within one system cycle
	assign f_rd = fmem[f_addr];
	always @(posedge clock)
		if (f_req === 1'b1 && f_we === 1'b1)
			fmem[f_addr] <= f_wd;

	task automatic chk(input logic ok, input string m);
		cmp_count++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask : chk

	task automatic close_out;
		$display("checks %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out

	////////////////////////////////////////////////////////////////////////////////
	// pin watcher and run limit
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc++;
		if (ahi_e | alo_e | d_e | wr_e | rd_e | ale_e)
			claim = 1'b1;
		if (ahi_e === 1'b1)
			ahi_seen = 1'b1;
		if (ale_o === 1'b1 && ale_e === 1'b1) begin
			ale_seen = 1'b1;
			ale_run++;
		end else if (ale_run != 0) begin
			ale_len = ale_run;
			ale_run = 0;
		end
		if (f_req === 1'b1)
			req_run++;
		else if (req_run != 0) begin
			req_len = req_run;
			req_run = 0;
		end
		if (rd_e === 1'b1 && rd_o === 1'b0)
			chk(d_e === 1'b0, "data driven during read");
		if (cyc == 8000) begin
			fail_count++;
			$display("ERROR %0t run limit reached", $time);
			close_out();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register bus master
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clock);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clock);
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : axi_rd

	task automatic run_row(input xem_row_t w);
		logic [31:0] st;
		logic [1:0]  rs;
		int          n;
		axi_wr(xem_pkg::OFF_CFG, {24'h0, w.cfg}, rs);
		axi_wr(xem_pkg::OFF_PAGE, {24'h0, w.hi}, rs);
		axi_wr(xem_pkg::OFF_DPH, {24'h0, w.hi}, rs);
		axi_wr(xem_pkg::OFF_DPL, {24'h0, w.lo}, rs);
		axi_wr(xem_pkg::OFF_IDX0, {24'h0, w.lo}, rs);
		axi_wr(xem_pkg::OFF_IDX1, {24'h0, w.lo}, rs);
		claim = 1'b0;
		ahi_seen = 1'b0;
		ale_seen = 1'b0;
		ale_len = 0;
		req_len = 0;
		axi_wr(xem_pkg::OFF_CMD, {20'h0, w.ctl, w.wd}, rs);
		n = 0;
		do begin
			axi_rd(xem_pkg::OFF_STAT, st, rs);
			n++;
		end while (st[8] !== 1'b0 && n < 100);
		chk(st[11:9] === w.tgt, "access target");
		if (!w.ctl[0])
			chk(st[7:0] === w.rd, "read byte");
		chk(claim === (w.tgt == 3'h3), "pin claim");
		if (w.tgt == 3'h3)
			chk(ahi_seen === !(w.cfg[3:2] == xem_pkg::MODE_NOBK && !w.ctl[1]), "high addr");
		chk(ale_seen === (w.tgt == 3'h3 && !w.cfg[4]), "latch strobe use");
		if (ale_seen === 1'b1)
			chk(ale_len == int'(w.cfg[1:0]) + 1, "latch strobe width");
		if (w.tgt == 3'h2)
			chk(req_len == 4, "window wait");
	endtask : run_row

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] st;
		logic [1:0]  rs;
		{awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
		{claim, ahi_seen, ale_seen, ale_run, ale_len, req_run, req_len} = '0;
		{cyc, fail_count, cmp_count} = '0;
		srst = 1'b1;
		repeat (16) @(posedge clock);
		srst <= 1'b0;
		foreach (rows[i])
			run_row(rows[i]);
		// command while busy is accepted but ignored
		axi_wr(xem_pkg::OFF_CFG, 32'h50, rs);
		axi_wr(xem_pkg::OFF_DPH, 32'h04, rs);
		axi_wr(xem_pkg::OFF_DPL, 32'h01, rs);
		axi_wr(xem_pkg::OFF_CMD, 32'h311, rs);
		axi_wr(xem_pkg::OFF_CMD, 32'h322, rs);
		chk(rs === xem_pkg::RESP_OK, "busy command response");
		run_row({8'h50, 8'h04, 8'h01, 4'h2, 8'h00, 3'h2, 8'h11});
		axi_wr(8'h20, 32'h0, rs);
		chk(rs === xem_pkg::RESP_ERR, "unmapped write");
		axi_rd(8'h06, st, rs);
		chk(rs === xem_pkg::RESP_ERR, "unaligned read");
		axi_wr(xem_pkg::OFF_CFG, 32'hFF, rs);
		axi_rd(xem_pkg::OFF_CFG, st, rs);
		chk(st === 32'h5F, "config unused bits");
		axi_wr(xem_pkg::OFF_DPH, 32'hAB, rs);
		axi_wr(xem_pkg::OFF_DPL, 32'hCD, rs);
		axi_rd(xem_pkg::OFF_DPH, st, rs);
		chk(st === 32'hAB, "pointer high");
		axi_rd(xem_pkg::OFF_DPL, st, rs);
		chk(st === 32'hCD, "pointer low");
		// second reset in mid-run
		@(posedge clock);
		srst <= 1'b1;
		repeat (16) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		chk({ahi_e, alo_e, d_e, wr_e, rd_e, ale_e, f_req} === 7'h00, "idle pins");
		foreach (ro[i]) begin
			axi_rd(ro[i], st, rs);
			chk(st === {24'h0, rv[i]} && rs === xem_pkg::RESP_OK, "reset value");
		end
		close_out();
	end
endmodule : external_data_space_external_memory_access_bench
`default_nettype wire
